// [logic/cra_pkg.sv]
// Function
// - Hard reset loads every non-sticky bit with its default value.
// - Sticky bits keep their state across a hard reset.
// - Read-only bits follow hardware; software writes change nothing.
// - Write-only bits store nothing; a write fires a hardware event pulse.
// - Read/write bits store the written value and read it back.
// - Clear-on-read bits return their value, then clear because of the read.
// - Clear-on-read writable bits clear after a read and accept writes.
// - Write-one-clear bits clear where one is written; zero does nothing.
// - Write-zero-clear bits clear where zero is written; one does nothing.
// - Write-one-set bits set where one is written; hardware clears them.
// - Write-zero-set bits set where zero is written; hardware clears them.
// - Lockable bits act read/write until hardware or the lock bit locks them.
// - Write-once bits take the first write after reset, then read-only.
// - Write-once freezing is tracked per byte lane, not per field.
// - Restricted-write fields ignore writes of unsupported values.
// - Lock-attributed bits become read-only once the lock bit is set.
// - Multi-byte fields are little-endian: low byte at lowest address.
// - Registers reachable by conventional and enhanced configuration access.
// - Own bus number comes from the maximum bus range and socket number.
// - Reserved locations complete normally, read zero, ignore writes.
// - Only the power-good reset returns sticky bits to their defaults.
package cra_pkg;
  localparam int CRA_DW = 32;
  localparam int CRA_AW = 12;
  localparam int CRA_IW = 10;
  // Dword indexes of the implemented registers (byte address 0x40..0x4C)
  localparam logic [9:0] CRA_IDX_CTRL = 10'h010;
  localparam logic [9:0] CRA_IDX_STAT = 10'h011;
  localparam logic [9:0] CRA_IDX_CMD = 10'h012;
  localparam logic [9:0] CRA_IDX_ONCE = 10'h013;
  // Byte lanes of the fields; lane n holds address offset n
  localparam int CRA_LN_RW = 0;
  localparam int CRA_LN_RRW = 1;
  localparam int CRA_LN_LOCK = 2;
  localparam int CRA_LN_RWL = 3;
  localparam int CRA_LN_RO = 0;
  localparam int CRA_LN_W1C = 1;
  localparam int CRA_LN_W0C = 2;
  localparam int CRA_LN_RC = 3;
  localparam int CRA_LN_W1S = 0;
  localparam int CRA_LN_W0S = 1;
  localparam int CRA_LN_WO = 2;
  localparam int CRA_LN_RCW = 3;
  localparam int CRA_LN_ONCE0 = 0;
  localparam int CRA_LN_ONCE1 = 1;
  localparam int CRA_LN_LFLD = 3;
  localparam int CRA_LOCK_BIT = 0;
  // Reset values
  localparam logic [7:0] CRA_RW_RST = 8'h00;
  localparam logic [7:0] CRA_RRW_RST = 8'h01;
  localparam logic [7:0] CRA_RWL_RST = 8'h00;
  localparam logic [7:0] CRA_STAT_RST = 8'h00;
  localparam logic [7:0] CRA_CMD_RST = 8'h00;
  localparam logic [15:0] CRA_ONCE_RST = 16'h0000;
  localparam logic [7:0] CRA_LFLD_RST = 8'h00;
  // Highest value the restricted field supports
  localparam logic [7:0] CRA_RRW_MAX = 8'h04;
  // Decoding of the own configuration address
  localparam logic [7:0] CRA_BUS_TOP = 8'hFF;
  localparam logic [4:0] CRA_OWN_DEV = 5'h00;
  localparam logic [2:0] CRA_OWN_FUNC = 3'h0;
endpackage : cra_pkg

// [logic/cra_cfg_decode.sv]
`timescale 1ns/10ps
module cra_cfg_decode (
  // Request address
  input wire logic enhanced_in,
  input wire logic [7:0] bus_in,
  input wire logic [4:0] dev_in,
  input wire logic [2:0] func_in,
  input wire logic [cra_pkg::CRA_AW-1:0] addr_in,
  // Bus numbering
  input wire logic [1:0] max_bus_range_in,
  input wire logic [2:0] socket_id_in,
  // Decode result
  output logic hit_out,
  output logic [cra_pkg::CRA_IW-1:0] index_out,
  output logic [7:0] own_bus_out
);
  import cra_pkg::*;

  // Each range step halves the bus space; sockets count down from the top
  assign own_bus_out = (CRA_BUS_TOP >> max_bus_range_in) - {5'h00, socket_id_in};
  // The conventional mechanism only reaches the first 256 bytes
  assign index_out = enhanced_in ? addr_in[11:2] : {4'h0, addr_in[7:2]};
  assign hit_out = (bus_in == own_bus_out) && (dev_in == CRA_OWN_DEV)
                   && (func_in == CRA_OWN_FUNC);
endmodule : cra_cfg_decode

// [logic/cra_config_regs.sv]
`timescale 1ns/10ps
module cra_config_regs (
  // Clock, resets, enable
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic hard_resetn_in,
  input wire logic ce_in,
  // Configuration access
  input wire logic cfg_req_in,
  input wire logic cfg_write_in,
  input wire logic cfg_enhanced_in,
  input wire logic [7:0] cfg_bus_in,
  input wire logic [4:0] cfg_dev_in,
  input wire logic [2:0] cfg_func_in,
  input wire logic [cra_pkg::CRA_AW-1:0] cfg_addr_in,
  input wire logic [3:0] cfg_byte_en_in,
  input wire logic [cra_pkg::CRA_DW-1:0] cfg_wdata_in,
  output logic cfg_ack_out,
  output logic cfg_hit_out,
  output logic [cra_pkg::CRA_DW-1:0] cfg_rdata_out,
  // Bus numbering
  input wire logic [1:0] max_bus_range_in,
  input wire logic [2:0] socket_id_in,
  // Hardware side
  input wire logic [7:0] hw_status_in,
  input wire logic [7:0] hw_event_in,
  input wire logic [7:0] hw_done_in,
  input wire logic hw_lock_in,
  output logic [7:0] write_event_trigger_out,
  output logic [7:0] ctrl_rw_out,
  output logic [7:0] restricted_write_out,
  output logic [7:0] lockable_readwrite_out,
  output logic config_lock_out,
  output logic [7:0] write_one_set_out,
  output logic [7:0] write_zero_set_out,
  output logic [15:0] write_once_bit_out,
  output logic [7:0] lock_field_out
);
  import cra_pkg::*;

  function automatic logic [7:0] set_clear(input logic [7:0] q, input logic [7:0] set,
                                           input logic [7:0] clr);
    // Set is applied last so a coincident event survives the clear
    set_clear = (q & ~clr) | set;
  endfunction : set_clear

  function automatic logic [7:0] lane(input logic [31:0] d, input int n);
    lane = d[8*n+:8];
  endfunction : lane

  logic hit;
  logic [CRA_IW-1:0] idx;
  logic wr, rd, wr_ctrl, wr_stat, wr_cmd, wr_once, rd_stat, rd_cmd;
  logic [31:0] rd_word;
  logic [7:0] rw_field, rrw_field, rwl_field, w1c_field, w0c_field, rc_field;
  logic [7:0] w1s_field, w0s_field, rcw_field, lfld, wo_pulse;
  logic [15:0] once_field, once_done;
  logic lock, ack, ack_hit;
  logic [31:0] rdata;
  logic [7:0] next_rw_field, next_rrw_field, next_rwl_field, next_w1c_field;
  logic [7:0] next_w0c_field, next_rc_field, next_w1s_field, next_w0s_field;
  logic [7:0] next_rcw_field, next_lfld, next_wo_pulse;
  logic [15:0] next_once_field, next_once_done, once_take;
  logic next_lock, next_ack, next_ack_hit;
  logic [31:0] next_rdata;

  cra_cfg_decode u_decode (
    .enhanced_in(cfg_enhanced_in),
    .bus_in(cfg_bus_in),
    .dev_in(cfg_dev_in),
    .func_in(cfg_func_in),
    .addr_in(cfg_addr_in),
    .max_bus_range_in(max_bus_range_in),
    .socket_id_in(socket_id_in),
    .hit_out(hit),
    .index_out(idx),
    .own_bus_out()
  );

  // Requests are ignored while the hard reset is held
  assign wr = cfg_req_in && cfg_write_in && hit && hard_resetn_in;
  assign rd = cfg_req_in && !cfg_write_in && hit && hard_resetn_in;
  assign wr_ctrl = wr && (idx == CRA_IDX_CTRL);
  assign wr_stat = wr && (idx == CRA_IDX_STAT);
  assign wr_cmd = wr && (idx == CRA_IDX_CMD);
  assign wr_once = wr && (idx == CRA_IDX_ONCE);
  assign rd_stat = rd && (idx == CRA_IDX_STAT);
  assign rd_cmd = rd && (idx == CRA_IDX_CMD);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (idx)
      CRA_IDX_CTRL: rd_word = {rwl_field, 7'h00, lock, rrw_field, rw_field};
      CRA_IDX_STAT: rd_word = {rc_field, w0c_field, w1c_field, hw_status_in};
      CRA_IDX_CMD: rd_word = {rcw_field, 8'h00, w0s_field, w1s_field};
      CRA_IDX_ONCE: rd_word = {lfld, 8'h00, once_field};
      default: rd_word = 32'h0000_0000;
    endcase
    // Lanes not enabled read as zero
    for (int n = 0; n < 4; n++)
      if (!cfg_byte_en_in[n])
        rd_word[8*n+:8] = 8'h00;
  end

  always_comb
  begin
    next_ack = cfg_req_in && hard_resetn_in;
    next_ack_hit = rd || wr;
    next_rdata = rdata;
    if (cfg_req_in && hard_resetn_in)
      next_rdata = rd ? rd_word : 32'h0000_0000;
    next_rw_field = rw_field;
    next_rrw_field = rrw_field;
    next_rwl_field = rwl_field;
    next_lock = lock;
    next_rcw_field = rcw_field;
    next_lfld = lfld;
    next_once_field = once_field;
    next_once_done = once_done;
    next_wo_pulse = 8'h00;
    if (wr_ctrl && cfg_byte_en_in[CRA_LN_RW])
      next_rw_field = lane(cfg_wdata_in, CRA_LN_RW);
    if (wr_ctrl && cfg_byte_en_in[CRA_LN_RRW]
        && lane(cfg_wdata_in, CRA_LN_RRW) <= CRA_RRW_MAX)
      next_rrw_field = lane(cfg_wdata_in, CRA_LN_RRW);
    // The lock bit itself can only be set; it falls with a reset
    if (wr_ctrl && cfg_byte_en_in[CRA_LN_LOCK])
      next_lock = lock | cfg_wdata_in[8*CRA_LN_LOCK+CRA_LOCK_BIT];
    if (wr_ctrl && cfg_byte_en_in[CRA_LN_RWL] && !lock && !hw_lock_in)
      next_rwl_field = lane(cfg_wdata_in, CRA_LN_RWL);
    next_w1c_field = set_clear(w1c_field, hw_event_in,
      (wr_stat && cfg_byte_en_in[CRA_LN_W1C]) ? lane(cfg_wdata_in, CRA_LN_W1C) : 8'h00);
    next_w0c_field = set_clear(w0c_field, hw_event_in,
      (wr_stat && cfg_byte_en_in[CRA_LN_W0C]) ? ~lane(cfg_wdata_in, CRA_LN_W0C) : 8'h00);
    next_rc_field = set_clear(rc_field, hw_event_in,
      (rd_stat && cfg_byte_en_in[CRA_LN_RC]) ? 8'hFF : 8'h00);
    // Software set beats a coincident hardware clear so a request is not dropped
    next_w1s_field = set_clear(w1s_field,
      (wr_cmd && cfg_byte_en_in[CRA_LN_W1S]) ? lane(cfg_wdata_in, CRA_LN_W1S) : 8'h00,
      hw_done_in);
    next_w0s_field = set_clear(w0s_field,
      (wr_cmd && cfg_byte_en_in[CRA_LN_W0S]) ? ~lane(cfg_wdata_in, CRA_LN_W0S) : 8'h00,
      hw_done_in);
    if (wr_cmd && cfg_byte_en_in[CRA_LN_WO])
      next_wo_pulse = lane(cfg_wdata_in, CRA_LN_WO);
    if (wr_cmd && cfg_byte_en_in[CRA_LN_RCW])
      next_rcw_field = lane(cfg_wdata_in, CRA_LN_RCW);
    else if (rd_cmd && cfg_byte_en_in[CRA_LN_RCW])
      next_rcw_field = 8'h00;
    // Each byte lane freezes on its own first write
    once_take = {{8{wr_once && cfg_byte_en_in[CRA_LN_ONCE1]}},
                 {8{wr_once && cfg_byte_en_in[CRA_LN_ONCE0]}}} & ~once_done;
    next_once_field = (once_field & ~once_take) | (cfg_wdata_in[15:0] & once_take);
    next_once_done = once_done | once_take;
    if (wr_once && cfg_byte_en_in[CRA_LN_LFLD] && !lock)
      next_lfld = lane(cfg_wdata_in, CRA_LN_LFLD);
    if (!hard_resetn_in)
    begin
      // The write-one-clear field is sticky: it keeps its bits here and still takes hardware events
      next_rw_field = CRA_RW_RST;
      next_rrw_field = CRA_RRW_RST;
      next_rwl_field = CRA_RWL_RST;
      next_lock = 1'b0;
      next_w0c_field = CRA_STAT_RST;
      next_rc_field = CRA_STAT_RST;
      next_w1s_field = CRA_CMD_RST;
      next_w0s_field = CRA_CMD_RST;
      next_rcw_field = CRA_CMD_RST;
      next_wo_pulse = 8'h00;
      next_once_field = CRA_ONCE_RST;
      next_once_done = 16'h0000;
      next_lfld = CRA_LFLD_RST;
      next_w1c_field = w1c_field | hw_event_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ack <= 1'b0;
      ack_hit <= 1'b0;
      rdata <= 32'h0000_0000;
      rw_field <= CRA_RW_RST;
      rrw_field <= CRA_RRW_RST;
      rwl_field <= CRA_RWL_RST;
      lock <= 1'b0;
      w1c_field <= CRA_STAT_RST;
      w0c_field <= CRA_STAT_RST;
      rc_field <= CRA_STAT_RST;
      w1s_field <= CRA_CMD_RST;
      w0s_field <= CRA_CMD_RST;
      rcw_field <= CRA_CMD_RST;
      wo_pulse <= 8'h00;
      once_field <= CRA_ONCE_RST;
      once_done <= 16'h0000;
      lfld <= CRA_LFLD_RST;
    end
    else if (ce_in)
    begin
      ack <= next_ack;
      ack_hit <= next_ack_hit;
      rdata <= next_rdata;
      rw_field <= next_rw_field;
      rrw_field <= next_rrw_field;
      rwl_field <= next_rwl_field;
      lock <= next_lock;
      w1c_field <= next_w1c_field;
      w0c_field <= next_w0c_field;
      rc_field <= next_rc_field;
      w1s_field <= next_w1s_field;
      w0s_field <= next_w0s_field;
      rcw_field <= next_rcw_field;
      wo_pulse <= next_wo_pulse;
      once_field <= next_once_field;
      once_done <= next_once_done;
      lfld <= next_lfld;
    end
  end

  // A frozen clock enable would stretch the pulse, so it is qualified here
  assign cfg_ack_out = ack && ce_in;
  assign cfg_hit_out = ack_hit;
  assign cfg_rdata_out = rdata;
  assign write_event_trigger_out = ce_in ? wo_pulse : 8'h00;
  assign ctrl_rw_out = rw_field;
  assign restricted_write_out = rrw_field;
  assign lockable_readwrite_out = rwl_field;
  assign config_lock_out = lock;
  assign write_one_set_out = w1s_field;
  assign write_zero_set_out = w0s_field;
  assign write_once_bit_out = once_field;
  assign lock_field_out = lfld;

  logic go;
  assign go = ce_in && hard_resetn_in;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_wo_write;
    go && wr_cmd && cfg_byte_en_in[CRA_LN_WO];
  endsequence
  sequence s_wo_pulse(logic [7:0] v);
    write_event_trigger_out == v ##1 (!ce_in || write_event_trigger_out == 8'h00);
  endsequence
  property p_wo_event;
    logic [7:0] v;
    (s_wo_write, v = cfg_wdata_in[23:16]) ##1 ce_in |-> s_wo_pulse(v);
  endproperty
  a_wo_event: assert property (p_wo_event) else $error("write event pulse wrong");

  property p_rw_store;
    go && wr_ctrl && cfg_byte_en_in[0] |=> rw_field == $past(cfg_wdata_in[7:0]);
  endproperty
  a_rw_store: assert property (p_rw_store) else $error("read/write field not stored");

  property p_ro_read;
    go && rd_stat && cfg_byte_en_in[0] |=> cfg_rdata_out[7:0] == $past(hw_status_in);
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("status byte not hardware value");

  property p_rc_clear;
    go && rd_stat && cfg_byte_en_in[3] && hw_event_in == 8'h00
      |=> rc_field == 8'h00 && cfg_rdata_out[31:24] == $past(rc_field);
  endproperty
  a_rc_clear: assert property (p_rc_clear) else $error("clear-on-read failed");

  property p_w1c;
    go && wr_stat && cfg_byte_en_in[1]
      |=> w1c_field == (($past(w1c_field) & ~$past(cfg_wdata_in[15:8])) | $past(hw_event_in));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-clear wrong");

  property p_set_wins;
    ce_in && hw_event_in[0] |=> w1c_field[0] && w0c_field[0] == $past(hard_resetn_in);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("hardware set lost");

  property p_sticky;
    ce_in && !hard_resetn_in && hw_event_in == 8'h00
      |=> $stable(w1c_field) && rw_field == CRA_RW_RST && rrw_field == CRA_RRW_RST;
  endproperty
  a_sticky: assert property (p_sticky) else $error("hard reset handling wrong");

  property p_rrw;
    go && wr_ctrl && cfg_byte_en_in[1] && cfg_wdata_in[15:8] > CRA_RRW_MAX |=> $stable(rrw_field);
  endproperty
  a_rrw: assert property (p_rrw) else $error("unsupported value stored");

  property p_locked;
    go && (lock || hw_lock_in) && wr_ctrl |=> $stable(rwl_field) && (!$past(lock) || $stable(lfld));
  endproperty
  a_locked: assert property (p_locked) else $error("locked field changed");

  property p_once;
    go && wr_once && once_done[0] |=> once_field[0] == $past(once_field[0]);
  endproperty
  a_once: assert property (p_once) else $error("write-once bit rewritten");
endmodule : cra_config_regs

// [tb/cra_host_model.sv]
`timescale 1ns/10ps
module cra_host_model (
  // Clock
  input wire logic clk_in,
  // Answer from the device
  input wire logic ack_in,
  input wire logic hit_in,
  input wire logic [31:0] rdata_in,
  // Request to the device
  output logic req_out,
  output logic write_out,
  output logic enhanced_out,
  output logic [7:0] bus_out,
  output logic [11:0] addr_out,
  output logic [3:0] byte_en_out,
  output logic [31:0] wdata_out
);
  initial
  begin
    req_out = 1'b0;
    write_out = 1'b0;
    enhanced_out = 1'b0;
    bus_out = 8'h00;
    addr_out = 12'h000;
    byte_en_out = 4'h0;
    wdata_out = 32'h00000000;
  end

  // A request is one cycle long; the single ack pulse is awaited for a bounded time
  task automatic access(input logic wr, input logic enh, input logic [7:0] bus,
      input logic [11:0] addr, input logic [3:0] be, input logic [31:0] wd,
      output logic [31:0] rd, output logic hit, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h00000000;
    hit = 1'b0;
    @(posedge clk_in);
    req_out <= 1'b1;
    write_out <= wr;
    enhanced_out <= enh;
    bus_out <= bus;
    addr_out <= addr;
    byte_en_out <= be;
    wdata_out <= wd;
    @(posedge clk_in);
    req_out <= 1'b0;
    // Released address, byte-enable and data lines carry the inverse so a stale value cannot pass for a live one
    addr_out <= ~addr;
    byte_en_out <= ~be;
    wdata_out <= ~wd;
    for (n = 0; n < 4 && !ok; n++)
    begin
      @(posedge clk_in);
      if (ack_in === 1'b1)
      begin
        ok = 1'b1;
        rd = rdata_in;
        hit = hit_in;
      end
    end
  endtask : access
endmodule : cra_host_model

// [tb/test_config_register_bit_attributes.sv]
`timescale 1ns/10ps
module test_config_register_bit_attributes;
  import cra_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic hard_resetn_in = 1'b1;
  logic ce_in = 1'b1;
  logic cfg_req_in, cfg_write_in, cfg_enhanced_in, cfg_ack_out, cfg_hit_out;
  logic [7:0] cfg_bus_in;
  logic [4:0] cfg_dev_in = 5'h00;
  logic [2:0] cfg_func_in = 3'h0;
  logic [11:0] cfg_addr_in;
  logic [3:0] cfg_byte_en_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, rv;
  logic [1:0] max_bus_range_in = 2'h1;
  logic [2:0] socket_id_in = 3'h2;
  logic [7:0] hw_status_in = 8'h3C;
  logic [7:0] hw_event_in = 8'h00;
  logic [7:0] hw_done_in = 8'h00;
  logic hw_lock_in = 1'b0;
  logic [7:0] write_event_trigger_out, ctrl_rw_out, restricted_write_out;
  logic [7:0] lockable_readwrite_out, write_one_set_out, write_zero_set_out, lock_field_out;
  logic config_lock_out, hv;
  logic [15:0] write_once_bit_out;
  logic [7:0] own = 8'h7D;
  int err_count = 0;
  int checks = 0;

  always #12.5 clk_in = ~clk_in;

  cra_config_regs dut (.clk_in, .resetn_in, .hard_resetn_in, .ce_in, .cfg_req_in,
    .cfg_write_in, .cfg_enhanced_in, .cfg_bus_in, .cfg_dev_in, .cfg_func_in, .cfg_addr_in,
    .cfg_byte_en_in, .cfg_wdata_in, .cfg_ack_out, .cfg_hit_out, .cfg_rdata_out,
    .max_bus_range_in, .socket_id_in, .hw_status_in, .hw_event_in, .hw_done_in, .hw_lock_in,
    .write_event_trigger_out, .ctrl_rw_out, .restricted_write_out, .lockable_readwrite_out,
    .config_lock_out, .write_one_set_out, .write_zero_set_out, .write_once_bit_out,
    .lock_field_out);

  cra_host_model host (.clk_in, .ack_in(cfg_ack_out), .hit_in(cfg_hit_out),
    .rdata_in(cfg_rdata_out), .req_out(cfg_req_in), .write_out(cfg_write_in),
    .enhanced_out(cfg_enhanced_in), .bus_out(cfg_bus_in), .addr_out(cfg_addr_in),
    .byte_en_out(cfg_byte_en_in), .wdata_out(cfg_wdata_in));

  task automatic wrap_up;
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic acc(input logic w, input logic e, input logic [7:0] b, input logic [11:0] a,
      input logic [3:0] be, input logic [31:0] d);
    logic ok;
    host.access(w, e, b, a, be, d, rv, hv, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED ack expected 1 seen 0");
      wrap_up();
    end
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, 1'b0, own, a, be, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [3:0] be);
    acc(1'b0, 1'b0, own, a, be, 32'h00000000);
  endtask : rd

  task automatic t_defaults;
    rd(12'h040, 4'hF);
    chk("ctrl", 32'h00000100, rv);
    rd(12'h048, 4'hF);
    chk("cmd", 32'h00000000, rv);
    rd(12'h04C, 4'hF);
    chk("once", 32'h00000000, rv);
  endtask : t_defaults

  task automatic t_rw_once;
    wr(12'h040, 4'h1, 32'h000000A5);
    rd(12'h040, 4'h1);
    chk("rw", 32'h000000A5, rv);
    wr(12'h040, 4'h2, 32'h00000300);
    chk("rrw", 32'h03, 32'(restricted_write_out));
    wr(12'h040, 4'h2, 32'h00000500);
    chk("rrw", 32'h03, 32'(restricted_write_out));
    wr(12'h04C, 4'h1, 32'h00000034);
    wr(12'h04C, 4'h3, 32'h00005612);
    chk("once", 32'h5634, 32'(write_once_bit_out));
    wr(12'h04C, 4'h3, 32'h0000FFFF);
    chk("once", 32'h5634, 32'(write_once_bit_out));
    rd(12'h04C, 4'h2);
    chk("once", 32'h00005600, rv);
  endtask : t_rw_once

  task automatic t_status;
    wr(12'h044, 4'h1, 32'h000000FF);
    rd(12'h044, 4'h1);
    chk("ro", 32'h0000003C, rv);
    @(posedge clk_in);
    hw_event_in <= 8'h81;
    @(posedge clk_in);
    hw_event_in <= 8'h00;
    rd(12'h044, 4'hF);
    chk("stat", 32'h8181813C, rv);
    rd(12'h044, 4'hF);
    chk("stat", 32'h0081813C, rv);
    wr(12'h044, 4'h6, 32'h00FE0100);
    rd(12'h044, 4'hF);
    chk("stat", 32'h0080803C, rv);
    @(posedge clk_in);
    hw_event_in <= 8'h02;
    wr(12'h044, 4'h2, 32'h00000200);
    hw_event_in <= 8'h00;
    rd(12'h044, 4'hF);
    chk("stat", 32'h0282823C, rv);
  endtask : t_status

  task automatic t_cmd;
    wr(12'h048, 4'h1, 32'h0000000F);
    wr(12'h048, 4'h1, 32'h00000000);
    chk("w1s", 32'h0F, 32'(write_one_set_out));
    @(posedge clk_in);
    hw_done_in <= 8'h03;
    @(posedge clk_in);
    hw_done_in <= 8'h00;
    @(posedge clk_in);
    chk("w1s", 32'h0C, 32'(write_one_set_out));
    wr(12'h048, 4'h2, 32'h0000F000);
    chk("w0s", 32'h0F, 32'(write_zero_set_out));
    wr(12'h048, 4'h4, 32'h005C0000);
    chk("evt", 32'h5C, 32'(write_event_trigger_out));
    @(posedge clk_in);
    chk("evt", 32'h00, 32'(write_event_trigger_out));
    rd(12'h048, 4'h4);
    chk("evt", 32'h00000000, rv);
    wr(12'h048, 4'h8, 32'h66000000);
    rd(12'h048, 4'h8);
    chk("rcw", 32'h66000000, rv);
    rd(12'h048, 4'h8);
    chk("rcw", 32'h00000000, rv);
  endtask : t_cmd

  task automatic t_lock;
    wr(12'h040, 4'h8, 32'h5A000000);
    @(posedge clk_in);
    hw_lock_in <= 1'b1;
    wr(12'h040, 4'h8, 32'h11000000);
    hw_lock_in <= 1'b0;
    chk("rwl", 32'h5A, 32'(lockable_readwrite_out));
    wr(12'h04C, 4'h8, 32'h77000000);
    wr(12'h040, 4'h4, 32'h00010000);
    chk("lock", 32'h1, 32'(config_lock_out));
    wr(12'h040, 4'h8, 32'h22000000);
    chk("rwl", 32'h5A, 32'(lockable_readwrite_out));
    wr(12'h04C, 4'h8, 32'h88000000);
    chk("lfld", 32'h77, 32'(lock_field_out));
  endtask : t_lock

  task automatic t_decode;
    wr(12'h050, 4'hF, 32'hFFFFFFFF);
    rd(12'h050, 4'hF);
    chk("rsvd", 32'h00000001, {rv[31:1], hv});
    acc(1'b0, 1'b1, own, 12'h140, 4'h1, 32'h00000000);
    chk("enh", 32'h00000001, {rv[31:1], hv});
    acc(1'b0, 1'b0, own, 12'h140, 4'h1, 32'h00000000);
    chk("conv", 32'h000000A5, rv);
    @(posedge clk_in);
    max_bus_range_in <= 2'h0;
    socket_id_in <= 3'h1;
    acc(1'b0, 1'b0, 8'h7D, 12'h040, 4'h1, 32'h00000000);
    chk("miss", 32'h00000000, {rv[31:1], hv});
    acc(1'b0, 1'b0, 8'hFE, 12'h040, 4'h1, 32'h00000000);
    chk("bus", 32'h00000001, 32'(hv));
  endtask : t_decode

  task automatic t_resets;
    @(posedge clk_in);
    hard_resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    hard_resetn_in <= 1'b1;
    @(posedge clk_in);
    chk("rw", 32'h00, 32'(ctrl_rw_out));
    chk("rrw", 32'h01, 32'(restricted_write_out));
    acc(1'b0, 1'b0, 8'hFE, 12'h044, 4'h2, 32'h00000000);
    chk("sticky", 32'h00008200, rv);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    @(posedge clk_in);
    resetn_in <= 1'b1;
    acc(1'b0, 1'b0, 8'hFE, 12'h044, 4'h2, 32'h00000000);
    chk("sticky", 32'h00000000, rv);
  endtask : t_resets

  initial
  begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_defaults();
    t_rw_once();
    t_status();
    t_cmd();
    t_lock();
    t_decode();
    t_resets();
    wrap_up();
  end
endmodule : test_config_register_bit_attributes
